// [bench/ict_sync_src.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// external sync source
// ---------------------------------------------------------------
module ict_sync_src (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic arm,
  input wire logic [7:0] hold,
  output logic sync_in
);
  logic [7:0] cnt;

  // sync stays low for hold cycles
  always_ff @(posedge core_clk) begin
    if (rst || !arm) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end

  // line low while not armed
  assign sync_in = arm && (cnt >= hold);
endmodule : ict_sync_src

// [bench/instruction_cycle_timing_test.sv]
`timescale 1ns/1ps
module instruction_cycle_timing_test;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  ict_pkg::ict_req_t req = '0;
  logic arm = 1'b0;
  logic [7:0] hold = 8'h00;
  logic sync_in, busy, done, seg_override;
  logic [1:0] seg_active;
  ict_pkg::ict_res_t res, nres;
  int errors = 0;
  int checked = 0;
  int seed = 32'h1f9530db;
  logic ie = 1'b0;
  logic step_flag = 1'b0;
  logic pre = 1'b0;
  int i;
  ict_pkg::ict_op_t op;
  ict_pkg::ict_op_t ops[11] = '{ict_pkg::ICT_OP_SEG_PREFIX,
    ict_pkg::ICT_OP_TRAP_STEP, ict_pkg::ICT_OP_RSH_REG1,
    ict_pkg::ICT_OP_RSH_REG_CNT, ict_pkg::ICT_OP_RSH_MEM1,
    ict_pkg::ICT_OP_IEN_SET, ict_pkg::ICT_OP_SSTR_ONE,
    ict_pkg::ICT_OP_SSTR_REP, ict_pkg::ICT_OP_XOR_RR,
    ict_pkg::ICT_OP_XOR_RM, ict_pkg::ICT_OP_XOR_MR};

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  ict_sync_src u_sync (.core_clk(core_clk), .rst(rst), .arm(arm),
    .hold(hold), .sync_in(sync_in));
  ict_core #(.NARROW_BUS(1'b0)) u_dut (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .sync_in(sync_in), .busy(busy),
    .done(done), .res(res), .seg_active(seg_active),
    .seg_override(seg_override));
  ict_core #(.NARROW_BUS(1'b1)) u_nar (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .sync_in(sync_in), .busy(),
    .done(), .res(nres), .seg_active(), .seg_override());

  // ---------------------------------------------------------------
  // expectations and checking
  // ---------------------------------------------------------------
  function automatic logic [7:0] xf(ict_pkg::ict_op_t o, logic [7:0] c);
    case (o)
      ict_pkg::ICT_OP_TRAP_STEP: return step_flag ? 8'h05 : 8'h00;
      ict_pkg::ICT_OP_RSH_MEM1, ict_pkg::ICT_OP_XOR_MR: return 8'h02;
      ict_pkg::ICT_OP_SSTR_ONE, ict_pkg::ICT_OP_XOR_RM: return 8'h01;
      ict_pkg::ICT_OP_SSTR_REP: return c;
      default: return 8'h00;
    endcase
  endfunction : xf

  function automatic logic [15:0] ck(ict_pkg::ict_op_t o, logic [7:0] c,
                                     logic [5:0] a);
    logic [15:0] cc, aa;
    cc = {8'h00, c};
    aa = {10'h000, a};
    case (o)
      ict_pkg::ICT_OP_TRAP_STEP: return step_flag ? 16'h0032 : 16'h0000;
      ict_pkg::ICT_OP_RSH_REG_CNT: return 16'h0008 + cc * 16'h0004;
      ict_pkg::ICT_OP_RSH_MEM1: return 16'h000f + aa;
      ict_pkg::ICT_OP_SSTR_ONE: return 16'h000b;
      ict_pkg::ICT_OP_SSTR_REP: return 16'h0009 + cc * 16'h000a;
      ict_pkg::ICT_OP_XOR_RR: return 16'h0003;
      ict_pkg::ICT_OP_XOR_RM: return 16'h0009 + aa;
      ict_pkg::ICT_OP_XOR_MR: return 16'h0010 + aa;
      default: return 16'h0002;
    endcase
  endfunction : ck

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // bounded wait for the result pulse
  task automatic wait_done(input int lim);
    for (int n = 0; n < lim && done !== 1'b1; n++) @(negedge core_clk);
    if (done !== 1'b1) begin
      errors++;
      $display("wrong value done expected 1 seen 0");
      tally_and_finish();
    end
  endtask : wait_done

  // one operation, always a word operand
  task automatic run(input ict_pkg::ict_op_t o, input logic [15:0] d,
                     input logic [15:0] s, input logic [7:0] c,
                     input logic [5:0] a, input logic odd);
    logic [7:0] x;
    logic [15:0] k, v;
    x = xf(o, c);
    k = ck(o, c, a);
    v = d ^ s;
    req = '{o, d, s, c, a, 1'b1, odd, c[1:0]};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    wait_done(400);
    if (o == ict_pkg::ICT_OP_IEN_SET)
      ie = 1'b1;
    if (o == ict_pkg::ICT_OP_TRAP_STEP && step_flag) begin
      ie = 1'b0;
      step_flag = 1'b0;
    end
    check("clocks", res.clocks, k + (odd ? {6'h00, x, 2'h0} : 16'h0000));
    check("narrow clocks", nres.clocks, k + {6'h00, x, 2'h0});
    check("transfers", {8'h00, res.transfers}, {8'h00, x});
    check("ie tf", res.flags & 16'h0300,
          {6'h00, ie, step_flag, 8'h00});
    check("override", {15'h0000, seg_override},
          {15'h0000, o != ict_pkg::ICT_OP_SEG_PREFIX && pre});
    if (o == ict_pkg::ICT_OP_SEG_PREFIX)
      check("segment", {14'h0000, seg_active}, {14'h0000, c[1:0]});
    if (o == ict_pkg::ICT_OP_RSH_REG_CNT)
      check("shift", res.value, d >> c);
    if (o == ict_pkg::ICT_OP_RSH_REG1 || o == ict_pkg::ICT_OP_RSH_MEM1)
      check("shift1", res.value, d >> 1);
    if (o >= ict_pkg::ICT_OP_XOR_RR) begin
      check("xor", res.value, v);
      check("xor flags", res.flags & 16'h08c5,
            {8'h00, v[15], v == 16'h0000, 3'h0, ~^v[7:0], 2'h0});
    end
    // trap hook shows only from the next result on
    if (o == ict_pkg::ICT_OP_IEN_SET)
      step_flag = step_flag | s[8];
    pre = (o == ict_pkg::ICT_OP_SEG_PREFIX);
    // gap so the strobe is not raised in the edge it fell
    @(negedge core_clk);
  endtask : run

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    run(ict_pkg::ICT_OP_XOR_RR, 16'h5a5a, 16'h5a5a, 8'h00, 6'h00, 1'b0);
    run(ict_pkg::ICT_OP_XOR_RM, 16'h8001, 16'h0000, 8'h00, 6'h3f, 1'b1);
    run(ict_pkg::ICT_OP_RSH_REG_CNT, 16'hffff, 16'h0000, 8'h10, 6'h00,
        1'b1);
    run(ict_pkg::ICT_OP_IEN_SET, 16'h0000, 16'h0100, 8'h00, 6'h00,
        1'b0);
    run(ict_pkg::ICT_OP_TRAP_STEP, 16'h0000, 16'h0000, 8'h00, 6'h00, 1'b1);
    run(ict_pkg::ICT_OP_TRAP_STEP, 16'h0000, 16'h0000, 8'h00, 6'h00, 1'b1);
    run(ict_pkg::ICT_OP_SSTR_REP, 16'h0000, 16'h0000, 8'h01, 6'h00,
        1'b1);
    $display("test corners finished");
    for (i = 0; i < 80; i++) begin
      op = (i < 11) ? ops[i] : ops[$unsigned($random(seed)) % 11];
      run(op, 16'($random(seed)), 16'($random(seed)),
          8'h01 + 8'($random(seed) & 15), 6'($random(seed)),
          1'($random(seed)));
    end
    $display("test random finished");
    hold = 8'($random(seed) & 31);
    req.op = ict_pkg::ICT_OP_WAIT;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    repeat (12) @(negedge core_clk);
    check("busy", {15'h0000, busy}, 16'h0001);
    req.op = ict_pkg::ICT_OP_XOR_RR;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    @(negedge core_clk);
    check("refused done", {15'h0000, done}, 16'h0000);
    arm = 1'b1;
    wait_done(80);
    arm = 1'b0;
    check("wait clocks", (res.clocks - 16'h0003) % 16'h0005, 16'h0000);
    check("wait transfers", {8'h00, res.transfers}, 16'h0000);
    $display("test wait finished");
    tally_and_finish();
  end
endmodule : instruction_cycle_timing_test

// [design/ict_core.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE1 - wide bus: odd word transfer adds four
// RULE2 - narrow bus: every word transfer adds four
// RULE3 - segment prefix: two clocks, redirects next access
// RULE4 - trap set: step interrupt, 50 clocks, clears
// RULE5 - interrupt enable set: two clocks, flag one
// RULE6 - string store: 11, or 9+10 per rep
// RULE7 - wait idles while sync input deasserted
// RULE8 - right shift zero fills, shift timings
// RULE9 - xor clears overflow carry, sets szp
// RULE10 - memory forms add address calculation time
module ict_core #(
  parameter bit NARROW_BUS = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire ict_pkg::ict_req_t req,
  input wire logic sync_in,
  output logic busy,
  output logic done,
  output ict_pkg::ict_res_t res,
  output logic [1:0] seg_active,
  output logic seg_override
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] word_pen(input logic word_op,
                                           input logic odd_addr,
                                           input logic [7:0] n);
    logic hit;
    hit = 1'b0;
    // RULE1 odd word penalty
    // RULE2 narrow word penalty
    hit = word_op && (NARROW_BUS || odd_addr);
    word_pen = hit ? 16'(ict_pkg::CLK_WORD_PENALTY * n) : 16'h0000;
  endfunction : word_pen

  function automatic logic [15:0] szp(input logic [15:0] f,
                                      input logic [15:0] v,
                                      input logic w);
    logic [15:0] r;
    r = f;
    r[ict_pkg::FLAG_SIGN] = w ? v[15] : v[7];
    r[ict_pkg::FLAG_ZERO] = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
    r[ict_pkg::FLAG_PARITY] = ~^v[7:0];
    szp = r;
  endfunction : szp

  logic [15:0] flags;
  logic waiting;
  logic [15:0] poll_cnt;
  logic [2:0] poll_div;
  logic sync_meta;
  logic sync_q;
  logic seg_pending;

  // -------------------------------------------------------------
  // sync input
  // -------------------------------------------------------------
  // two flops before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_meta <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sync_meta <= sync_in;
      sync_q <= sync_meta;
    end
  end

  // -------------------------------------------------------------
  // wait state
  // -------------------------------------------------------------
  // RULE7 idle while sync low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waiting <= 1'b0;
      poll_cnt <= 16'h0000;
      poll_div <= 3'h0;
    end else if (waiting) begin
      if (sync_q) begin
        waiting <= 1'b0;
      end else if (poll_div == 3'h4) begin
        poll_div <= 3'h0;
        poll_cnt <= poll_cnt + 16'h0001;
      end else begin
        poll_div <= poll_div + 3'h1;
      end
    end else if (req_valid && req.op == ict_pkg::ICT_OP_WAIT) begin
      waiting <= 1'b1;
      poll_cnt <= 16'h0000;
      poll_div <= 3'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= waiting && !sync_q;
    end
  end

  // -------------------------------------------------------------
  // segment override
  // -------------------------------------------------------------
  // RULE3 redirect next operand access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seg_pending <= 1'b0;
      seg_active <= 2'h0;
      seg_override <= 1'b0;
    end else if (req_valid && !waiting) begin
      if (req.op == ict_pkg::ICT_OP_SEG_PREFIX) begin
        seg_pending <= 1'b1;
        seg_active <= req.seg_sel;
        seg_override <= 1'b0;
      end else begin
        seg_override <= seg_pending;
        seg_pending <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // execute and flags
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags <= ict_pkg::FLAGS_RESET;
      done <= 1'b0;
      res <= '0;
    end else begin
      done <= 1'b0;
      if (waiting && sync_q) begin
        // RULE7 wait cost
        done <= 1'b1;
        res.value <= 16'h0000;
        res.clocks <= 16'(ict_pkg::CLK_WAIT_BASE
                          + ict_pkg::CLK_WAIT_POLL * poll_cnt);
        res.transfers <= 8'h00;
        res.flags <= flags;
      end else if (req_valid && !waiting &&
                   req.op != ict_pkg::ICT_OP_WAIT) begin
        done <= 1'b1;
        res.value <= req.dst;
        res.transfers <= 8'h00;
        res.flags <= flags;
        unique case (req.op)
          ict_pkg::ICT_OP_SEG_PREFIX: begin
            // RULE3 prefix cost
            res.clocks <= ict_pkg::CLK_SEG;
          end
          ict_pkg::ICT_OP_TRAP_STEP: begin
            // RULE4 step interrupt
            if (flags[ict_pkg::FLAG_TRAP]) begin
              res.clocks <= 16'(ict_pkg::CLK_TRAP
                                + word_pen(1'b1, req.odd_addr,
                                           ict_pkg::XFER_TRAP));
              res.transfers <= ict_pkg::XFER_TRAP;
              flags[ict_pkg::FLAG_TRAP] <= 1'b0;
              flags[ict_pkg::FLAG_IE] <= 1'b0;
              res.flags <= flags & ~(16'h0001 << ict_pkg::FLAG_TRAP)
                                 & ~(16'h0001 << ict_pkg::FLAG_IE);
            end else begin
              res.clocks <= 16'h0000;
            end
          end
          ict_pkg::ICT_OP_IEN_SET: begin
            // RULE5 enable set
            res.clocks <= ict_pkg::CLK_IEN;
            flags[ict_pkg::FLAG_IE] <= 1'b1;
            res.flags <= flags | (16'h0001 << ict_pkg::FLAG_IE);
          end
          ict_pkg::ICT_OP_RSH_REG1: begin
            // RULE8 zero fill
            res.value <= req.dst >> 1;
            res.clocks <= ict_pkg::CLK_RSH_REG1;
          end
          ict_pkg::ICT_OP_RSH_REG_CNT: begin
            // RULE8 counted shift
            res.value <= req.dst >> req.count;
            res.clocks <= 16'(ict_pkg::CLK_RSH_CNT_BASE
                              + ict_pkg::CLK_RSH_PER_BIT * req.count);
          end
          ict_pkg::ICT_OP_RSH_MEM1: begin
            // RULE10 address time added
            res.value <= req.dst >> 1;
            res.clocks <= 16'(ict_pkg::CLK_RSH_MEM1 + req.addr_time
                              + word_pen(req.word_op, req.odd_addr,
                                         ict_pkg::XFER_RSH_MEM1));
            res.transfers <= ict_pkg::XFER_RSH_MEM1;
          end
          ict_pkg::ICT_OP_SSTR_ONE: begin
            // RULE6 single store
            res.value <= req.src;
            res.clocks <= 16'(ict_pkg::CLK_SSTR_ONE
                              + word_pen(req.word_op, req.odd_addr,
                                         8'h01));
            res.transfers <= 8'h01;
          end
          ict_pkg::ICT_OP_SSTR_REP: begin
            // RULE6 repeated store
            res.value <= req.src;
            res.clocks <= 16'(ict_pkg::CLK_SSTR_BASE
                              + ict_pkg::CLK_SSTR_PER_REP * req.count
                              + word_pen(req.word_op, req.odd_addr,
                                         req.count));
            res.transfers <= req.count;
          end
          ict_pkg::ICT_OP_XOR_RR, ict_pkg::ICT_OP_XOR_RM,
          ict_pkg::ICT_OP_XOR_MR: begin
            // RULE9 xor flags
            res.value <= req.dst ^ req.src;
            flags <= szp(flags, req.dst ^ req.src, req.word_op)
                     & ~(16'h0001 << ict_pkg::FLAG_OVF)
                     & ~(16'h0001 << ict_pkg::FLAG_CARRY);
            res.flags <= szp(flags, req.dst ^ req.src, req.word_op)
                         & ~(16'h0001 << ict_pkg::FLAG_OVF)
                         & ~(16'h0001 << ict_pkg::FLAG_CARRY);
            if (req.op == ict_pkg::ICT_OP_XOR_RR) begin
              res.clocks <= ict_pkg::CLK_XOR_RR;
            end else if (req.op == ict_pkg::ICT_OP_XOR_RM) begin
              // RULE10 address time added
              res.clocks <= 16'(ict_pkg::CLK_XOR_RM + req.addr_time
                                + word_pen(req.word_op, req.odd_addr,
                                           ict_pkg::XFER_XOR_RM));
              res.transfers <= ict_pkg::XFER_XOR_RM;
            end else begin
              res.clocks <= 16'(ict_pkg::CLK_XOR_MR + req.addr_time
                                + word_pen(req.word_op, req.odd_addr,
                                           ict_pkg::XFER_XOR_MR));
              res.transfers <= ict_pkg::XFER_XOR_MR;
            end
          end
          default: begin
            res.clocks <= 16'h0000;
          end
        endcase
      end
      // trap flag loaded by the interrupt enable set op from src bit 8
      if (req_valid && !waiting && req.op == ict_pkg::ICT_OP_IEN_SET &&
          req.src[ict_pkg::FLAG_TRAP]) begin
        flags[ict_pkg::FLAG_TRAP] <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_ien_sets_ie: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_IEN_SET |=>
    done && res.flags[ict_pkg::FLAG_IE] && res.clocks == 16'h0002)
    else $error("enable set op wrong"); // RULE5
  a_seg_cost: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_SEG_PREFIX |=>
    res.clocks == 16'h0002 && res.transfers == 8'h00)
    else $error("prefix cost wrong"); // RULE3
  a_xor_flags: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_XOR_RR |=>
    !res.flags[ict_pkg::FLAG_OVF] && !res.flags[ict_pkg::FLAG_CARRY]
    && res.clocks == 16'h0003)
    else $error("xor result wrong"); // RULE9
  a_rsh_fill: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_RSH_REG1 |=>
    res.value == ($past(req.dst) >> 1) && res.clocks == 16'h0002)
    else $error("shift wrong"); // RULE8
  a_sstr_one: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_SSTR_ONE
    && !(req.word_op && (NARROW_BUS || req.odd_addr))
    |=> res.clocks == 16'h000b && res.transfers == 8'h01)
    else $error("store cost wrong"); // RULE6
  a_trap_clear: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_TRAP_STEP
    && flags[ict_pkg::FLAG_TRAP] |=> res.transfers == 8'h05
    && !flags[ict_pkg::FLAG_TRAP] && !flags[ict_pkg::FLAG_IE])
    else $error("step interrupt wrong"); // RULE4
  a_wait_idle: assert property (@(posedge core_clk) disable iff (rst)
    waiting && !sync_q |=> busy)
    else $error("wait not idle"); // RULE7
  a_word_pen: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_XOR_RM
    && req.word_op && (NARROW_BUS || req.odd_addr) |=>
    res.clocks == 16'(16'h000d + $past(req.addr_time)))
    else $error("word penalty wrong"); // RULE1
  a_ea_added: assert property (@(posedge core_clk) disable iff (rst)
    req_valid && !waiting && req.op == ict_pkg::ICT_OP_XOR_MR
    && !(req.word_op && (NARROW_BUS || req.odd_addr))
    |=> res.clocks == 16'(16'h0010 + $past(req.addr_time)))
    else $error("address time missing"); // RULE10

endmodule : ict_core

// [design/ict_pkg.sv]
package ict_pkg;
  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ICT_OP_SEG_PREFIX,
    ICT_OP_TRAP_STEP,
    ICT_OP_RSH_REG1,
    ICT_OP_RSH_REG_CNT,
    ICT_OP_RSH_MEM1,
    ICT_OP_IEN_SET,
    ICT_OP_SSTR_ONE,
    ICT_OP_SSTR_REP,
    ICT_OP_WAIT,
    ICT_OP_XOR_RR,
    ICT_OP_XOR_RM,
    ICT_OP_XOR_MR
  } ict_op_t;

  // ---------------------------------------------------------------
  // request and result carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    ict_op_t op;
    logic [15:0] dst;
    logic [15:0] src;
    logic [7:0] count;
    logic [5:0] addr_time;
    logic word_op;
    logic odd_addr;
    logic [1:0] seg_sel;
  } ict_req_t;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] clocks;
    logic [7:0] transfers;
    logic [15:0] flags;
  } ict_res_t;

  // ---------------------------------------------------------------
  // flag bit positions
  // ---------------------------------------------------------------
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_AUX = 4;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_TRAP = 8;
  localparam int FLAG_IE = 9;
  localparam int FLAG_OVF = 11;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // clock figures
  // ---------------------------------------------------------------
  localparam logic [15:0] CLK_SEG = 16'h0002;
  localparam logic [15:0] CLK_TRAP = 16'h0032;
  localparam logic [7:0] XFER_TRAP = 8'h05;
  localparam logic [15:0] CLK_IEN = 16'h0002;
  localparam logic [15:0] CLK_RSH_REG1 = 16'h0002;
  localparam logic [15:0] CLK_RSH_CNT_BASE = 16'h0008;
  localparam logic [15:0] CLK_RSH_PER_BIT = 16'h0004;
  localparam logic [15:0] CLK_RSH_MEM1 = 16'h000f;
  localparam logic [7:0] XFER_RSH_MEM1 = 8'h02;
  localparam logic [15:0] CLK_SSTR_ONE = 16'h000b;
  localparam logic [15:0] CLK_SSTR_BASE = 16'h0009;
  localparam logic [15:0] CLK_SSTR_PER_REP = 16'h000a;
  localparam logic [15:0] CLK_WAIT_BASE = 16'h0003;
  localparam logic [15:0] CLK_WAIT_POLL = 16'h0005;
  localparam logic [15:0] CLK_XOR_RR = 16'h0003;
  localparam logic [15:0] CLK_XOR_RM = 16'h0009;
  localparam logic [15:0] CLK_XOR_MR = 16'h0010;
  localparam logic [7:0] XFER_XOR_RM = 8'h01;
  localparam logic [7:0] XFER_XOR_MR = 8'h02;
  localparam logic [15:0] CLK_WORD_PENALTY = 16'h0004;
endpackage : ict_pkg
